// ===== verilog/psm_pkg.sv
/*
 * Constants for the power-state I/O monitor: configuration-space byte
 * offsets, control bit positions, reset values and the field layout of
 * the clock divisor report.
 * Assumes a byte-wide configuration access port on the core clock.
 */
package psm_pkg;
   localparam logic [7:0] OFS_DS_ADDR   = 8'hE8;
   localparam logic [7:0] OFS_DS_MASK   = 8'hEA;
   localparam logic [7:0] OFS_DS_CMP    = 8'hEC;
   localparam logic [7:0] OFS_DS_CTL    = 8'hEE;
   localparam logic [7:0] OFS_SUSPEND_RAM_WATCH_ADDRESS  = 8'hF0;
   localparam logic [7:0] OFS_SUSPEND_RAM_WATCH_MASK  = 8'hF2;
   localparam logic [7:0] OFS_STR_CMP   = 8'hF4;
   localparam logic [7:0] OFS_SUSPEND_RAM_WATCH_CONTROL   = 8'hF6;
   localparam logic [7:0] OFS_FREQ      = 8'hFC;
   localparam logic [7:0] OFS_MEMORY_CLOCK_DIVISORS    = 8'hFE;
   localparam logic [7:0] OFS_BUSDIV    = 8'hFF;
   localparam int         CTL_RD_BIT    = 0;
   localparam int         CTL_WR_BIT    = 1;
   localparam logic [15:0] RST_HALF     = 16'h0000;
   localparam logic [1:0]  RST_CTL      = 2'h0;
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam int         DDR_DIV_LSB   = 4;
   localparam int         SDR_DIV_LSB   = 0;
endpackage

// ===== verilog/psm_monitor.sv
/*
 * Power-state I/O monitor: configuration registers for the deep-sleep
 * and suspend-to-RAM watch units, plus read-only clock reports.
 * Assumes byte-wide configuration accesses on mclk (one-cycle strobes),
 * I/O access observations as one-cycle strobes on mclk, and that the
 * clock report values are stable straps sampled after reset release.
 * stop_clock_request arrives from a pin and is synchronised here.
 */
module psm_monitor
   import psm_pkg::*;
(
   input  wire logic        mclk,                // core clock
   input  wire logic        resetn,              // async reset, low
   input  wire logic        clk_en,              // freezes state when low
   input  wire logic [7:0]  cfg_addr,            // config byte offset
   input  wire logic        cfg_wr,              // config write strobe
   input  wire logic        cfg_rd,              // config read strobe
   input  wire logic [7:0]  cfg_wdata,           // config write byte
   output logic      [7:0]  cfg_rdata,           // config read byte
   input  wire logic        io_valid,            // observed I/O access
   input  wire logic        io_write,            // 1 write, 0 read
   input  wire logic [15:0] io_port,             // I/O port address
   input  wire logic [15:0] io_data,             // I/O access data
   input  wire logic        stop_clock_request,  // pin, async
   input  wire logic [15:0] core_freq_mhz,       // strap, MHz
   input  wire logic [3:0]  ddr_clock_divisor,   // strap
   input  wire logic [3:0]  sdr_clock_divisor,   // strap
   input  wire logic [7:0]  bus_clock_divisor,   // strap
   output logic             ds_armed,            // deep sleep pending
   output logic             str_armed,           // suspend pending
   output logic             ds_enter,            // deep sleep pulse
   output logic             str_enter            // suspend pulse
);
   logic [15:0] ds_addr_r, ds_mask_r, ds_cmp_r;
   logic [15:0] suspend_ram_watch_address_r, suspend_ram_watch_mask_r, str_cmp_r;
   logic [1:0]  ds_ctl_r, suspend_ram_watch_control_r;
   logic [15:0] freq_r;
   logic [7:0]  memory_clock_divisors_r, busdiv_r;
   logic        cap_done_r;
   logic [2:0]  stp_sync_r;
   logic        stp_level_r;
   logic        ds_armed_r, str_armed_r;
   logic        ds_enter_r, str_enter_r;
   logic [7:0]  rdata_r;

   wire wr_en = cfg_wr & clk_en;

   // stop-clock edge once second and third stages agree
   wire stp_agree = stp_sync_r[1] == stp_sync_r[2];
   wire stp_rise  = stp_agree & stp_sync_r[2] & ~stp_level_r;

   // watch decode per unit
   wire ds_hit = io_valid && (io_port == ds_addr_r)
      && ((io_write && ds_ctl_r[CTL_WR_BIT])
      || (!io_write && ds_ctl_r[CTL_RD_BIT]));
   wire ds_match = ds_hit
      && ((io_data & ds_mask_r) == ds_cmp_r);
   wire str_hit = io_valid && (io_port == suspend_ram_watch_address_r)
      && ((io_write && suspend_ram_watch_control_r[CTL_WR_BIT])
      || (!io_write && suspend_ram_watch_control_r[CTL_RD_BIT]));
   wire str_match = str_hit
      && ((io_data & suspend_ram_watch_mask_r) == str_cmp_r);

   // a new match wins over the stop-clock consume
   wire ds_armed_nxt  = ds_match | (ds_armed_r & ~stp_rise);
   wire str_armed_nxt = str_match | (str_armed_r & ~stp_rise);

   // read mux; reserved control bits read zero
   logic [7:0] rd_mux;
   always_comb begin
      case (cfg_addr)
         OFS_DS_ADDR:       rd_mux = ds_addr_r[7:0];
         OFS_DS_ADDR+8'h01: rd_mux = ds_addr_r[15:8];
         OFS_DS_MASK:       rd_mux = ds_mask_r[7:0];
         OFS_DS_MASK+8'h01: rd_mux = ds_mask_r[15:8];
         OFS_DS_CMP:        rd_mux = ds_cmp_r[7:0];
         OFS_DS_CMP+8'h01:  rd_mux = ds_cmp_r[15:8];
         OFS_DS_CTL:        rd_mux = {6'h00, ds_ctl_r};
         OFS_SUSPEND_RAM_WATCH_ADDRESS:       rd_mux = suspend_ram_watch_address_r[7:0];
         OFS_SUSPEND_RAM_WATCH_ADDRESS+8'h01: rd_mux = suspend_ram_watch_address_r[15:8];
         OFS_SUSPEND_RAM_WATCH_MASK:       rd_mux = suspend_ram_watch_mask_r[7:0];
         OFS_SUSPEND_RAM_WATCH_MASK+8'h01: rd_mux = suspend_ram_watch_mask_r[15:8];
         OFS_STR_CMP:        rd_mux = str_cmp_r[7:0];
         OFS_STR_CMP+8'h01:  rd_mux = str_cmp_r[15:8];
         OFS_SUSPEND_RAM_WATCH_CONTROL:        rd_mux = {6'h00, suspend_ram_watch_control_r};
         OFS_FREQ:           rd_mux = freq_r[7:0];
         OFS_FREQ+8'h01:     rd_mux = freq_r[15:8];
         OFS_MEMORY_CLOCK_DIVISORS:         rd_mux = memory_clock_divisors_r;
         OFS_BUSDIV:         rd_mux = busdiv_r;
         default:            rd_mux = 8'h00;
      endcase
   end

   // 16-bit register written one byte lane at a time
   function automatic logic [15:0] put_byte(input logic [15:0] cur,
                                            input logic hi,
                                            input logic [7:0] b);
      put_byte = hi ? {b, cur[7:0]} : {cur[15:8], b};
   endfunction

   wire sel_ds_addr  = cfg_addr[7:1] == OFS_DS_ADDR[7:1];
   wire sel_ds_mask  = cfg_addr[7:1] == OFS_DS_MASK[7:1];
   wire sel_ds_cmp   = cfg_addr[7:1] == OFS_DS_CMP[7:1];
   wire sel_suspend_ram_watch_address = cfg_addr[7:1] == OFS_SUSPEND_RAM_WATCH_ADDRESS[7:1];
   wire sel_suspend_ram_watch_mask = cfg_addr[7:1] == OFS_SUSPEND_RAM_WATCH_MASK[7:1];
   wire sel_str_cmp  = cfg_addr[7:1] == OFS_STR_CMP[7:1];

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ds_addr_r  <= RST_HALF;
         ds_mask_r  <= RST_HALF;
         ds_cmp_r   <= RST_HALF;
         suspend_ram_watch_address_r <= RST_HALF;
         suspend_ram_watch_mask_r <= RST_HALF;
         str_cmp_r  <= RST_HALF;
         ds_ctl_r   <= RST_CTL;
         suspend_ram_watch_control_r  <= RST_CTL;
      end else if (wr_en) begin
         if (sel_ds_addr)
            ds_addr_r <= put_byte(ds_addr_r, cfg_addr[0], cfg_wdata);
         if (sel_ds_mask)
            ds_mask_r <= put_byte(ds_mask_r, cfg_addr[0], cfg_wdata);
         if (sel_ds_cmp)
            ds_cmp_r <= put_byte(ds_cmp_r, cfg_addr[0], cfg_wdata);
         if (sel_suspend_ram_watch_address)
            suspend_ram_watch_address_r <= put_byte(suspend_ram_watch_address_r, cfg_addr[0], cfg_wdata);
         if (sel_suspend_ram_watch_mask)
            suspend_ram_watch_mask_r <= put_byte(suspend_ram_watch_mask_r, cfg_addr[0], cfg_wdata);
         if (sel_str_cmp)
            str_cmp_r <= put_byte(str_cmp_r, cfg_addr[0], cfg_wdata);
         if (cfg_addr == OFS_DS_CTL)
            ds_ctl_r <= cfg_wdata[1:0];
         if (cfg_addr == OFS_SUSPEND_RAM_WATCH_CONTROL)
            suspend_ram_watch_control_r <= cfg_wdata[1:0];
      end
   end

   // report straps caught once, first enabled edge after release
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         freq_r     <= RST_HALF;
         memory_clock_divisors_r   <= RST_BYTE;
         busdiv_r   <= RST_BYTE;
         cap_done_r <= 1'b0;
      end else if (clk_en && !cap_done_r) begin
         freq_r     <= core_freq_mhz;
         memory_clock_divisors_r   <= {ddr_clock_divisor, sdr_clock_divisor};
         busdiv_r   <= bus_clock_divisor;
         cap_done_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stp_sync_r  <= 3'h0;
         stp_level_r <= 1'b0;
      end else if (clk_en) begin
         stp_sync_r <= {stp_sync_r[1:0], stop_clock_request};
         if (stp_agree)
            stp_level_r <= stp_sync_r[2];
      end
   end

   // a match arriving with the stop-clock edge stays armed for the next
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ds_armed_r  <= 1'b0;
         str_armed_r <= 1'b0;
         ds_enter_r  <= 1'b0;
         str_enter_r <= 1'b0;
         rdata_r     <= RST_BYTE;
      end else if (clk_en) begin
         ds_enter_r  <= stp_rise & ds_armed_r;
         str_enter_r <= stp_rise & str_armed_r;
         ds_armed_r  <= ds_armed_nxt;
         str_armed_r <= str_armed_nxt;
         if (cfg_rd)
            rdata_r <= rd_mux;
      end
   end

   assign ds_armed  = ds_armed_r;
   assign str_armed = str_armed_r;
   assign ds_enter  = ds_enter_r;
   assign str_enter = str_enter_r;
   assign cfg_rdata = rdata_r;

   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence str_fire_s;
      clk_en && str_armed_r && stp_rise;
   endsequence
   sequence ds_fire_s;
      clk_en && ds_armed_r && stp_rise;
   endsequence

   ds_write_arm_a: assert property (
      clk_en && io_valid && io_write && ds_ctl_r[CTL_WR_BIT]
      && io_port == ds_addr_r && (io_data & ds_mask_r) == ds_cmp_r
      |=> ds_armed_r) else $error("deep sleep write match not armed");
   ds_read_arm_a: assert property (
      clk_en && io_valid && !io_write && ds_ctl_r[CTL_RD_BIT]
      && io_port == ds_addr_r && (io_data & ds_mask_r) == ds_cmp_r
      |=> ds_armed_r) else $error("deep sleep read match not armed");
   str_write_arm_a: assert property (
      clk_en && io_valid && io_write && suspend_ram_watch_control_r[CTL_WR_BIT]
      && io_port == suspend_ram_watch_address_r && (io_data & suspend_ram_watch_mask_r) == str_cmp_r
      |=> str_armed_r) else $error("suspend write match not armed");
   str_read_arm_a: assert property (
      clk_en && io_valid && !io_write && suspend_ram_watch_control_r[CTL_RD_BIT]
      && io_port == suspend_ram_watch_address_r && (io_data & suspend_ram_watch_mask_r) == str_cmp_r
      |=> str_armed_r) else $error("suspend read match not armed");
   str_fire_pulse_a: assert property (
      str_fire_s |=> str_enter_r ##1 !str_enter_r || !clk_en)
      else $error("suspend entry not a single pulse");
   ds_fire_pulse_a: assert property (
      ds_fire_s |=> ds_enter_r) else $error("deep sleep entry missed");
   ds_idle_quiet_a: assert property (
      clk_en && ds_ctl_r == 2'h0 && !ds_armed_r |=> !ds_armed_r)
      else $error("disabled deep sleep unit armed");
   suspend_ram_watch_address_full_a: assert property (
      clk_en && !str_armed_r && (!io_valid || io_port != suspend_ram_watch_address_r)
      |=> !str_armed_r) else $error("suspend armed without address hit");
   ctl_reserved_a: assert property (
      clk_en && cfg_rd && cfg_addr == OFS_SUSPEND_RAM_WATCH_CONTROL
      |=> cfg_rdata[7:2] == 6'h00) else $error("reserved bits nonzero");
   memory_clock_divisors_read_a: assert property (
      clk_en && cfg_rd && cfg_addr == OFS_MEMORY_CLOCK_DIVISORS
      |=> cfg_rdata == memory_clock_divisors_r) else $error("divisor readback wrong");

   // consume and pulse steps of a stop-clock entry
   sequence ds_consume_s;
      clk_en && ds_armed_r && stp_rise && !ds_match;
   endsequence
   sequence str_consume_s;
      clk_en && str_armed_r && stp_rise && !str_match;
   endsequence
   sequence ds_pulse_s;
      ds_enter_r ##1 (!ds_enter_r || !clk_en);
   endsequence
   sequence str_pulse_s;
      str_enter_r ##1 (!str_enter_r || !clk_en);
   endsequence

   // stop-clock consume and entry pulses
   ds_fire_clear_a: assert property (
      ds_consume_s |=> !ds_armed_r)
      else $error("deep sleep still armed after entry");
   str_fire_clear_a: assert property (
      str_consume_s |=> !str_armed_r)
      else $error("suspend still armed after entry");
   ds_fire_once_a: assert property (
      ds_fire_s |=> ds_pulse_s)
      else $error("deep sleep entry not a single pulse");
   str_fire_once_a: assert property (
      str_fire_s |=> str_pulse_s)
      else $error("suspend entry pulse malformed");
   ds_enter_cause_a: assert property (
      clk_en && !(ds_armed_r && stp_rise) |=> !ds_enter_r)
      else $error("deep sleep entry without cause");
   str_enter_cause_a: assert property (
      clk_en && !(str_armed_r && stp_rise) |=> !str_enter_r)
      else $error("suspend entry without cause");
   ds_armed_hold_a: assert property (
      clk_en && ds_armed_r && !stp_rise |=> ds_armed_r)
      else $error("deep sleep arm lost early");
   str_armed_hold_a: assert property (
      clk_en && str_armed_r && !stp_rise |=> str_armed_r)
      else $error("suspend arm lost early");
   ds_set_wins_a: assert property (
      clk_en && ds_match |=> ds_armed_r)
      else $error("deep sleep match dropped");
   str_set_wins_a: assert property (
      clk_en && str_match |=> str_armed_r)
      else $error("suspend match dropped");

   // nothing arms without a full hit
   str_idle_quiet_a: assert property (
      clk_en && suspend_ram_watch_control_r == 2'h0 && !str_armed_r |=> !str_armed_r)
      else $error("disabled suspend unit armed");
   ds_addr_full_a: assert property (
      clk_en && !ds_armed_r && (!io_valid || io_port != ds_addr_r)
      |=> !ds_armed_r) else $error("deep sleep armed without hit");
   suspend_ram_watch_mask_miss_a: assert property (
      clk_en && !str_armed_r && (io_data & suspend_ram_watch_mask_r) != str_cmp_r
      |=> !str_armed_r) else $error("suspend armed on masked miss");
   ds_mask_miss_a: assert property (
      clk_en && !ds_armed_r && (io_data & ds_mask_r) != ds_cmp_r
      |=> !ds_armed_r) else $error("deep sleep armed on masked miss");
   str_no_write_a: assert property (
      clk_en && !str_armed_r && io_write && !suspend_ram_watch_control_r[CTL_WR_BIT]
      |=> !str_armed_r) else $error("suspend armed on unwatched write");
   str_no_read_a: assert property (
      clk_en && !str_armed_r && !io_write && !suspend_ram_watch_control_r[CTL_RD_BIT]
      |=> !str_armed_r) else $error("suspend armed on unwatched read");
   ds_no_write_a: assert property (
      clk_en && !ds_armed_r && io_write && !ds_ctl_r[CTL_WR_BIT]
      |=> !ds_armed_r) else $error("deep sleep armed on write");
   ds_no_read_a: assert property (
      clk_en && !ds_armed_r && !io_write && !ds_ctl_r[CTL_RD_BIT]
      |=> !ds_armed_r) else $error("deep sleep armed on read");

   // register file and read path
   ds_ctl_reserved_a: assert property (
      clk_en && cfg_rd && cfg_addr == OFS_DS_CTL
      |=> cfg_rdata[7:2] == 6'h00) else $error("reserved bits nonzero");
   suspend_ram_watch_control_write_a: assert property (
      clk_en && cfg_wr && cfg_addr == OFS_SUSPEND_RAM_WATCH_CONTROL
      |=> suspend_ram_watch_control_r == $past(cfg_wdata[1:0])) else $error("ctl write lost");
   ds_ctl_write_a: assert property (
      clk_en && cfg_wr && cfg_addr == OFS_DS_CTL
      |=> ds_ctl_r == $past(cfg_wdata[1:0])) else $error("ctl write lost");
   freq_read_a: assert property (
      clk_en && cfg_rd && cfg_addr == OFS_FREQ
      |=> cfg_rdata == freq_r[7:0]) else $error("frequency low byte wrong");
   freq_hi_read_a: assert property (
      clk_en && cfg_rd && cfg_addr == OFS_FREQ + 8'h01
      |=> cfg_rdata == freq_r[15:8]) else $error("frequency high wrong");
   busdiv_read_a: assert property (
      clk_en && cfg_rd && cfg_addr == OFS_BUSDIV
      |=> cfg_rdata == busdiv_r) else $error("bus divisor readback wrong");
   rdata_hold_a: assert property (
      !(clk_en && cfg_rd) |=> $stable(cfg_rdata))
      else $error("read data changed without a read");
   straps_held_a: assert property (
      clk_en && cap_done_r
      |=> $stable(freq_r) && $stable(memory_clock_divisors_r) && $stable(busdiv_r))
      else $error("clock report changed after capture");

   // clock enable and stop-clock synchroniser
   freeze_hold_a: assert property (
      !clk_en |=> $stable(ds_armed_r) && $stable(str_armed_r)
      && $stable(ds_ctl_r) && $stable(suspend_ram_watch_control_r))
      else $error("state moved while clock enable low");
   sync_agree_a: assert property (
      stp_rise |-> stp_sync_r[1] && stp_sync_r[2])
      else $error("stop-clock edge before stages agree");
   sync_level_a: assert property (
      clk_en && stp_rise |=> stp_level_r)
      else $error("stop-clock level not updated");
endmodule

// ===== dv/psm_monitor_test.sv
/*
 * Self-checking bench for the power-state I/O monitor: register reset
 * values and access kinds, both watch units, and stop-clock firing.
 * Assumes the design package and psm_monitor from verilog/.
 */
module psm_monitor_test
   import psm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk = 0, resetn = 0, cfg_wr = 0, cfg_rd = 0;
   logic        io_valid = 0, io_write = 0, stop_clock_request = 0;
   logic        clk_en = 1;
   logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
   logic [15:0] io_port = 16'h0000, io_data = 16'h0000;
   logic        ds_armed, str_armed, ds_enter, str_enter;
   int          failures = 0, cmp_count = 0;
   localparam logic [15:0] FREQ = 16'h02A3;
   localparam logic [3:0]  DDR = 4'h5, SDR = 4'hA;
   localparam logic [7:0]  BUSD = 8'h3C;

   psm_monitor i_dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en),
      .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .io_valid(io_valid),
      .io_write(io_write), .io_port(io_port), .io_data(io_data),
      .stop_clock_request(stop_clock_request), .core_freq_mhz(FREQ),
      .ddr_clock_divisor(DDR), .sdr_clock_divisor(SDR),
      .bus_clock_divisor(BUSD), .ds_armed(ds_armed), .str_armed(str_armed),
      .ds_enter(ds_enter), .str_enter(str_enter));

   always #4 mclk = ~mclk;

   task automatic check(input string what, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cfg_addr = a; cfg_wdata = d; cfg_wr = 1;
      @(posedge mclk); #1; cfg_wr = 0;
      @(posedge mclk); #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      cfg_addr = a; cfg_rd = 1;
      @(posedge mclk); #1; cfg_rd = 0;
      @(posedge mclk); #1; d = cfg_rdata;
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a, d[7:0]); wr(8'(a + 8'h01), d[15:8]);
   endtask
   task automatic chk16(input logic [7:0] a, input logic [15:0] exp);
      logic [7:0] lo, hi;
      rd(a, lo); rd(8'(a + 8'h01), hi);
      check($sformatf("reg16 %h", a), {hi, lo}, exp);
   endtask
   task automatic chkb(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check($sformatf("reg8 %h", a), {8'h00, d}, {8'h00, exp});
   endtask
   // one observed I/O access, then the armed flags one cycle later
   task automatic io(input logic w, input logic [15:0] p, d,
                     input logic exp_ds, exp_str);
      io_valid = 1; io_write = w; io_port = p; io_data = d;
      @(posedge mclk); #1; io_valid = 0;
      @(posedge mclk); #1;
      check("ds_armed", {15'h0, ds_armed}, {15'h0, exp_ds});
      check("str_armed", {15'h0, str_armed}, {15'h0, exp_str});
   endtask
   // raise stop-clock and look for the enter pulse within ten cycles
   task automatic fire(input logic exp_ds, exp_str);
      logic sd, ss;
      sd = 0; ss = 0; stop_clock_request = 1;
      for (int i = 0; i < 10 && !(sd || ss); i++) begin
         @(posedge mclk); #1; sd = ds_enter; ss = str_enter;
      end
      check("ds_enter", {15'h0, sd}, {15'h0, exp_ds});
      check("str_enter", {15'h0, ss}, {15'h0, exp_str});
      check("armed after", {14'h0, ds_armed, str_armed}, 16'h0000);
      @(posedge mclk); #1;
      check("enter pulse", {14'h0, ds_enter, str_enter}, 16'h0000);
      stop_clock_request = 0;
      repeat (6) @(posedge mclk);
      #1;
   endtask

   // offsets of the six 16-bit watch registers
   function automatic logic [7:0] half_ofs(input int i);
      half_ofs = (i < 3) ? 8'(OFS_DS_ADDR + 2 * i)
                         : 8'(OFS_SUSPEND_RAM_WATCH_ADDRESS + 2 * (i - 3));
   endfunction

   task automatic t_reset;
      for (int i = 0; i < 6; i++) chk16(half_ofs(i), RST_HALF);
      chkb(OFS_DS_CTL, 8'h00);
      chkb(OFS_SUSPEND_RAM_WATCH_CONTROL, 8'h00);
      wr16(OFS_FREQ, 16'hFFFF); wr(OFS_MEMORY_CLOCK_DIVISORS, 8'h00); wr(OFS_BUSDIV, 8'h00);
      chk16(OFS_FREQ, FREQ);
      chkb(OFS_MEMORY_CLOCK_DIVISORS, {DDR, SDR});
      chkb(OFS_BUSDIV, BUSD);
      wr(8'h40, 8'hFF);
      chkb(8'h40, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_regs;
      for (int i = 0; i < 6; i++) wr16(half_ofs(i), 16'(16'hA51C + i));
      for (int i = 0; i < 6; i++)
         chk16(half_ofs(i), 16'(16'hA51C + i));
      wr(OFS_DS_CTL, 8'hFF); wr(OFS_SUSPEND_RAM_WATCH_CONTROL, 8'hFF);
      chkb(OFS_DS_CTL, 8'h03);
      chkb(OFS_SUSPEND_RAM_WATCH_CONTROL, 8'h03);
      wr(OFS_DS_CTL, 8'h00); wr(OFS_SUSPEND_RAM_WATCH_CONTROL, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_str;
      wr16(OFS_SUSPEND_RAM_WATCH_ADDRESS, 16'h1234); wr16(OFS_SUSPEND_RAM_WATCH_MASK, 16'h0FF0);
      wr16(OFS_STR_CMP, 16'h0A50); wr(OFS_SUSPEND_RAM_WATCH_CONTROL, 8'h02);
      io(0, 16'h1234, 16'h0A50, 0, 0);
      io(1, 16'h1235, 16'h0A50, 0, 0);
      io(1, 16'h1234, 16'h0AFF, 0, 0);
      io(1, 16'h1234, 16'hFA5F, 0, 1);
      fire(0, 1);
      wr(OFS_SUSPEND_RAM_WATCH_CONTROL, 8'h01);
      io(1, 16'h1234, 16'h0A50, 0, 0);
      io(0, 16'h1234, 16'h0A5F, 0, 1);
      fire(0, 1);
      $display("test suspend done");
   endtask
   task automatic t_ds;
      wr(OFS_SUSPEND_RAM_WATCH_CONTROL, 8'h00);
      wr16(OFS_DS_ADDR, 16'h00B2); wr16(OFS_DS_MASK, 16'hFFFF);
      wr16(OFS_DS_CMP, 16'h5AA5); wr(OFS_DS_CTL, 8'h01);
      io(1, 16'h00B2, 16'h5AA5, 0, 0);
      io(0, 16'h80B2, 16'h5AA5, 0, 0);
      io(0, 16'h00B2, 16'h5AA4, 0, 0);
      io(0, 16'h00B2, 16'h5AA5, 1, 0);
      fire(1, 0);
      wr(OFS_DS_CTL, 8'h02);
      io(1, 16'h00B2, 16'h5AA5, 1, 0);
      fire(1, 0);
      wr(OFS_DS_CTL, 8'h00); wr(OFS_SUSPEND_RAM_WATCH_CONTROL, 8'h00);
      io(1, 16'h00B2, 16'h5AA5, 0, 0);
      io(0, 16'h00B2, 16'h5AA5, 0, 0);
      fire(0, 0);
      $display("test deep sleep done");
   endtask
   // a write with the clock enable low must not land
   task automatic t_freeze;
      clk_en = 0;
      wr(OFS_SUSPEND_RAM_WATCH_CONTROL, 8'h03);
      clk_en = 1;
      chkb(OFS_SUSPEND_RAM_WATCH_CONTROL, 8'h00);
      $display("test freeze done");
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      #1; resetn = 1;
      repeat (2) @(posedge mclk);
      #1;
      t_reset();
      t_regs();
      t_str();
      t_ds();
      t_freeze();
      final_report();
   end
   initial begin
      #200000;
      failures++;
      final_report();
   end
endmodule
